//--- rtl/cbt_cfg.svh
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH
// ==========================================================
// register offsets
`define CBT_OFS_DBT 16'h100C
`define CBT_OFS_CTRL 16'h1018
`define CBT_OFS_NBT 16'h101C
`define CBT_OFS_TDC 16'h1048
`define CBT_OFS_STAT 16'h1050
`define CBT_OFS_STDF 16'h1084
`define CBT_OFS_EXTF 16'h1088
`define CBT_OFS_RXFA 16'h10A0
`define CBT_OFS_RXBF 16'h10AC
`define CBT_OFS_RXFB 16'h10B0
`define CBT_OFS_TXBF 16'h10C0
`define CBT_OFS_TXEV 16'h10F0
// ==========================================================
// message memory, 2 kB of 32-bit words
`define CBT_MEM_SEL 15
`define CBT_MEM_WORDS 512
`define CBT_MEM_IDX 10:2
// section slots in the base table
`define CBT_SEC_NUM 7
`define CBT_SEC_NONE 3'h7
`define CBT_SEC_RXB 4
`define CBT_SEC_TXE 5
// ==========================================================
// field positions
`define CBT_F_SJW 31:25
`define CBT_F_PRE 24:16
`define CBT_F_TS1 15:8
`define CBT_F_TS2 6:0
`define CBT_F_TDCO 6:0
`define CBT_F_BASE 15:2
`define CBT_C_INIT 0
`define CBT_C_CCE 1
`define CBT_S_UNC 0
`define CBT_S_CORR 1
`define CBT_S_OVR 2
// ==========================================================
// reset values
`define CBT_RST_NBT 32'h02030601
`define CBT_RST_DBT 32'h02030601
`define CBT_RST_TDC 32'h00000000
// ==========================================================
// serial frame: 1 direction bit, 16 address bits, 32 data bits
`define CBT_SPI_ADDR_END 6'h10
`define CBT_SPI_LAST 6'h30
`define CBT_SPI_LEN 6'h31
`endif

//--- rtl/cbt_pkg.sv
package cbt_pkg;
  // ========================================================
  // segment of the bit currently running
  typedef enum logic [1:0] {
    CBT_SEG_SYNC = 2'b00,
    CBT_SEG_PH1 = 2'b01,
    CBT_SEG_PH2 = 2'b10
  } cbt_seg_t;
  // owner of the memory port this cycle
  typedef enum logic [1:0] {
    CBT_GNT_NONE = 2'b00,
    CBT_GNT_HOST = 2'b01,
    CBT_GNT_EVT = 2'b10,
    CBT_GNT_RXW = 2'b11
  } cbt_gnt_t;
endpackage

//--- rtl/cbt_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  // occupancy and handshakes
  assign cnt = wp_q - rp_q;
  assign in_ready_o = cnt != (AW+1)'(DEPTH);
  assign out_valid_o = cnt != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = buf_q[rp_q[AW-1:0]];
  // storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      buf_q[wp_q[AW-1:0]] <= in_data_i;
  end
  // pointers, one lap bit above the index
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q[AW-1:0] == AW'(DEPTH-1)) ? {~wp_q[AW], {AW{1'b0}}} : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q[AW-1:0] == AW'(DEPTH-1)) ? {~rp_q[AW], {AW{1'b0}}} : rp_q + 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_FIFO_FILL:
  assert property (push && !pop |=> cnt == $past(cnt) + 1'b1)
    else $error("fifo count did not rise on a lone push");
endmodule
`default_nettype wire

//--- rtl/cbt_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbt_cfg.svh"

module cbt_core #(
  parameter int FIFO_DEPTH = 8,
  parameter int RX_BUF_WORDS = 18,
  parameter int TXE_DEPTH = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // host serial register port
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // can line and protocol engine
  input wire logic can_rx_i,
  input wire logic data_phase_i,
  input wire logic frame_start_i,
  input wire logic tx_done_i,
  output logic rx_bit_o,
  output logic rx_bit_strobe_o,
  output logic bit_start_o,
  output cbt_pkg::cbt_seg_t segment_o,
  // mode and memory health
  output logic init_mode_o,
  output logic ecc_corrected_o,
  output logic uncorrectable_memory_error_o
);
  import cbt_pkg::*;

  // ========================================================
  // functions
  // hamming syndrome of 32 data bits placed on non power-of-two positions
  function automatic logic [5:0] ham(input logic [31:0] d);
    logic [5:0] s;
    int k;
    s = 6'h00;
    k = 0;
    for (int q = 1; q < 39; q++)
    begin
      if ((q & (q - 1)) != 0)
      begin
        if (d[k])
          s = s ^ q[5:0];
        k = k + 1;
      end
    end
    return s;
  endfunction
  // flip the data bit whose position equals the syndrome
  function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] s);
    logic [31:0] r;
    int k;
    r = d;
    k = 0;
    for (int q = 1; q < 39; q++)
    begin
      if ((q & (q - 1)) != 0)
      begin
        if (q[5:0] == s)
          r[k] = ~r[k];
        k = k + 1;
      end
    end
    return r;
  endfunction
  // section slot addressed by a register offset
  function automatic logic [2:0] base_idx(input logic [15:0] a);
    case (a)
      `CBT_OFS_STDF: base_idx = 3'h0;
      `CBT_OFS_EXTF: base_idx = 3'h1;
      `CBT_OFS_RXFA: base_idx = 3'h2;
      `CBT_OFS_RXFB: base_idx = 3'h3;
      `CBT_OFS_RXBF: base_idx = 3'h4;
      `CBT_OFS_TXEV: base_idx = 3'h5;
      `CBT_OFS_TXBF: base_idx = 3'h6;
      default: base_idx = `CBT_SEC_NONE;
    endcase
  endfunction

  // ========================================================
  // declarations
  logic sclk_q, rw_q, rd_go_q, wr_go_q, rd_p_q, miso_q, miso_oe_q;
  logic [5:0] cnt_q;
  logic [15:0] addr_q;
  logic [31:0] wd_q, rd_sh_q, rmux, nbt_q, dbt_q, tdc_q, tm, pw_q, mem_wd, f_out_data;
  logic [13:0] base_q [`CBT_SEC_NUM];
  logic [2:0] bsel;
  logic init_q, cce_q, unc_q, corr_q, ovr_q, corr_o_q, prot_ok, wr_reg, sclk_rise, sclk_fall;
  logic [38:0] mem_q [`CBT_MEM_WORDS];
  logic [38:0] mem_rd_q;
  logic [`CBT_MEM_WORDS-1:0] wval_q;
  logic mem_vld_q, mem_we, host_mem, unc_evt, corr_evt;
  logic [5:0] syn;
  logic [8:0] mem_idx, last_idx_q, pre_q, tq_q, n_idx, sp;
  cbt_gnt_t gnt;
  cbt_seg_t seg_q, seg_d;
  logic run, tq_en, bitlast, fast_q, strobe_q, rxb_q, bstart_q;
  logic [31:0] as_q;
  logic [4:0] as_n_q;
  logic push_q, f_in_ready, f_out_valid, f_out_ready;
  logic [8:0] rx_widx_q;
  logic ev_pend_q, ev_word_q;
  logic [3:0] ev_slot_q;
  logic [7:0] ev_seq_q;
  logic [15:0] ts_q;

  // ========================================================
  // host serial port, mode 0, clock sampled by clk_i
  assign sclk_rise = !cs_b_i && sclk_i && !sclk_q;
  assign sclk_fall = !cs_b_i && !sclk_i && sclk_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk_i;
  end
  // direction, address and write data shift in on rising edges
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= 6'h00;
      rw_q <= 1'b0;
      addr_q <= 16'h0000;
      wd_q <= 32'h00000000;
      rd_go_q <= 1'b0;
      wr_go_q <= 1'b0;
    end
    else
    begin
      rd_go_q <= sclk_rise && cnt_q == `CBT_SPI_ADDR_END && rw_q;
      wr_go_q <= sclk_rise && cnt_q == `CBT_SPI_LAST && !rw_q;
      if (cs_b_i)
        cnt_q <= 6'h00;
      else if (sclk_rise && cnt_q != `CBT_SPI_LEN)
      begin
        cnt_q <= cnt_q + 6'h01;
        if (cnt_q == 6'h00)
          rw_q <= mosi_i;
        else if (cnt_q <= `CBT_SPI_ADDR_END)
          addr_q <= {addr_q[14:0], mosi_i};
        else
          wd_q <= {wd_q[30:0], mosi_i};
      end
    end
  end
  // read data loads two cycles after the address, then shifts on falling edges
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_sh_q <= 32'h00000000;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end
    else
    begin
      miso_oe_q <= !cs_b_i && rw_q && cnt_q > `CBT_SPI_ADDR_END;
      if (rd_p_q)
        rd_sh_q <= addr_q[`CBT_MEM_SEL] ? ecc_fix(mem_rd_q[31:0], syn) : rmux;
      else if (sclk_fall && rw_q && cnt_q > `CBT_SPI_ADDR_END)
      begin
        miso_q <= rd_sh_q[31];
        rd_sh_q <= {rd_sh_q[30:0], 1'b0};
      end
    end
  end

  // ========================================================
  // register file
  assign wr_reg = wr_go_q && !addr_q[`CBT_MEM_SEL];
  assign prot_ok = init_q && cce_q;
  assign bsel = base_idx(addr_q);
  // register read mux, unmapped offsets read zero
  always_comb
  begin
    rmux = 32'h00000000;
    case (addr_q)
      `CBT_OFS_DBT: rmux = dbt_q;
      `CBT_OFS_NBT: rmux = nbt_q;
      `CBT_OFS_TDC: rmux = tdc_q;
      `CBT_OFS_CTRL: rmux = {30'h00000000, cce_q, init_q};
      `CBT_OFS_STAT: rmux = {27'h0000000, init_q, 1'b0, ovr_q, corr_q, unc_q};
      default:
        if (bsel != `CBT_SEC_NONE)
          rmux = {16'h0000, base_q[bsel], 2'b00};
    endcase
  end
  // timing words, writable only in configuration mode
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      nbt_q <= `CBT_RST_NBT;
      dbt_q <= `CBT_RST_DBT;
      tdc_q <= `CBT_RST_TDC;
    end
    else if (wr_reg && prot_ok)
    begin
      if (addr_q == `CBT_OFS_NBT)
        nbt_q <= wd_q;
      if (addr_q == `CBT_OFS_DBT)
        dbt_q <= wd_q;
      if (addr_q == `CBT_OFS_TDC)
        tdc_q <= wd_q;
    end
  end
  // seven section start fields, bits 15:2 kept, low two bits dropped
  for (genvar g = 0; g < `CBT_SEC_NUM; g++)
  begin : g_base
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        base_q[g] <= 14'h0000;
      else if (wr_reg && prot_ok && bsel == 3'(g))
        base_q[g] <= wd_q[`CBT_F_BASE];
    end
  end
  // mode control; a memory fault wins over a host write
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      init_q <= 1'b1;
      cce_q <= 1'b0;
    end
    else
    begin
      if (wr_reg && addr_q == `CBT_OFS_CTRL)
      begin
        init_q <= wd_q[`CBT_C_INIT];
        cce_q <= wd_q[`CBT_C_CCE] && wd_q[`CBT_C_INIT];
      end
      if (unc_evt)
        init_q <= 1'b1;
    end
  end
  // sticky status, write one to clear, a new event wins
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      unc_q <= 1'b0;
      corr_q <= 1'b0;
      corr_o_q <= 1'b0;
    end
    else
    begin
      corr_o_q <= corr_evt;
      if (wr_reg && addr_q == `CBT_OFS_STAT && wd_q[`CBT_S_UNC])
        unc_q <= 1'b0;
      if (wr_reg && addr_q == `CBT_OFS_STAT && wd_q[`CBT_S_CORR])
        corr_q <= 1'b0;
      if (unc_evt)
        unc_q <= 1'b1;
      if (corr_evt)
        corr_q <= 1'b1;
    end
  end

  // ========================================================
  // message memory with per-word check bits
  assign host_mem = (rd_go_q || wr_go_q) && addr_q[`CBT_MEM_SEL];
  assign f_out_ready = !host_mem && !ev_pend_q;
  // port owner: host first, then event element, then received words
  always_comb
  begin
    gnt = CBT_GNT_NONE;
    mem_idx = addr_q[`CBT_MEM_IDX];
    mem_wd = wd_q;
    if (host_mem)
      gnt = CBT_GNT_HOST;
    else if (ev_pend_q)
    begin
      gnt = CBT_GNT_EVT;
      mem_idx = base_q[`CBT_SEC_TXE][8:0] + {4'h0, ev_slot_q, ev_word_q};
      mem_wd = ev_word_q ? {16'h0000, ts_q} : {24'h000000, ev_seq_q};
    end
    else if (f_out_valid)
    begin
      gnt = CBT_GNT_RXW;
      mem_idx = base_q[`CBT_SEC_RXB][8:0] + rx_widx_q;
      mem_wd = f_out_data;
    end
  end
  assign mem_we = (gnt == CBT_GNT_HOST && wr_go_q) || gnt == CBT_GNT_EVT || gnt == CBT_GNT_RXW;
  // array write, check bits computed only here
  always_ff @(posedge clk_i)
  begin
    if (mem_we)
      mem_q[mem_idx] <= {^{mem_wd, ham(mem_wd)}, ham(mem_wd), mem_wd};
    if (rd_go_q)
      mem_rd_q <= mem_q[mem_idx];
  end
  // written-word map stands in for power-up check bits that match nothing
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wval_q <= '0;
      mem_vld_q <= 1'b0;
      rd_p_q <= 1'b0;
      last_idx_q <= 9'h000;
    end
    else
    begin
      rd_p_q <= rd_go_q;
      last_idx_q <= mem_idx;
      if (rd_go_q)
        mem_vld_q <= wval_q[mem_idx];
      if (mem_we)
        wval_q[mem_idx] <= 1'b1;
    end
  end
  // decode: single error corrected, double or unwritten uncorrectable
  assign syn = ham(mem_rd_q[31:0]) ^ mem_rd_q[37:32];
  assign unc_evt = rd_p_q && addr_q[`CBT_MEM_SEL] &&
    (!mem_vld_q || (syn != 6'h00 && !(^mem_rd_q)));
  assign corr_evt = rd_p_q && addr_q[`CBT_MEM_SEL] && mem_vld_q && (^mem_rd_q);

  // ========================================================
  // bit timing engine
  assign run = !init_q;
  assign tm = fast_q ? dbt_q : nbt_q;
  assign tq_en = run && pre_q == tm[`CBT_F_PRE];
  assign bitlast = tq_q == 9'(tm[`CBT_F_TS1]) + 9'(tm[`CBT_F_TS2]) + 9'h002;
  assign n_idx = bitlast ? 9'h000 : tq_q + 9'h001;
  assign sp = 9'(tm[`CBT_F_TS1]) + 9'h002 + (fast_q ? 9'(tdc_q[`CBT_F_TDCO]) : 9'h000);
  // segment of the next quantum
  always_comb
  begin
    if (n_idx == 9'h000)
      seg_d = CBT_SEG_SYNC;
    else if (n_idx <= 9'(tm[`CBT_F_TS1]) + 9'h001)
      seg_d = CBT_SEG_PH1;
    else
      seg_d = CBT_SEG_PH2;
  end
  // prescaler and quantum counter
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pre_q <= 9'h000;
      tq_q <= 9'h000;
      seg_q <= CBT_SEG_SYNC;
      fast_q <= 1'b0;
    end
    else if (!run)
    begin
      pre_q <= 9'h000;
      tq_q <= 9'h000;
      seg_q <= CBT_SEG_SYNC;
      fast_q <= 1'b0;
    end
    else
    begin
      pre_q <= tq_en ? 9'h000 : pre_q + 9'h001;
      if (tq_en)
      begin
        tq_q <= n_idx;
        seg_q <= seg_d;
        if (bitlast)
          fast_q <= data_phase_i;
      end
    end
  end
  // sample, bit start pulse and bit-time stamp
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strobe_q <= 1'b0;
      rxb_q <= 1'b1;
      bstart_q <= 1'b0;
      ts_q <= 16'h0000;
    end
    else
    begin
      strobe_q <= tq_en && n_idx == sp;
      bstart_q <= tq_en && bitlast;
      if (tq_en && n_idx == sp)
        rxb_q <= can_rx_i;
      if (tq_en && bitlast)
        ts_q <= ts_q + 16'h0001;
    end
  end

  // ========================================================
  // receive words into the buffer section through the fifo
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      as_q <= 32'h00000000;
      as_n_q <= 5'h00;
      push_q <= 1'b0;
      pw_q <= 32'h00000000;
      ovr_q <= 1'b0;
    end
    else
    begin
      if (push_q && f_in_ready)
        push_q <= 1'b0;
      if (wr_reg && addr_q == `CBT_OFS_STAT && wd_q[`CBT_S_OVR])
        ovr_q <= 1'b0;
      if (frame_start_i || !run)
        as_n_q <= 5'h00;
      else if (strobe_q)
      begin
        as_q <= {as_q[30:0], rxb_q};
        as_n_q <= as_n_q + 5'h01;
        if (as_n_q == 5'h1F && push_q && !f_in_ready)
          ovr_q <= 1'b1;
        else if (as_n_q == 5'h1F)
        begin
          push_q <= 1'b1;
          pw_q <= {as_q[30:0], rxb_q};
        end
      end
    end
  end
  cbt_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push_q),
    .in_ready_o(f_in_ready),
    .in_data_i(pw_q),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out_data)
  );
  // drain index restarts each frame so old contents are overwritten
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rx_widx_q <= 9'h000;
    else if (frame_start_i)
      rx_widx_q <= 9'h000;
    else if (gnt == CBT_GNT_RXW)
      rx_widx_q <= (rx_widx_q == 9'(RX_BUF_WORDS - 1)) ? 9'h000 : rx_widx_q + 9'h001;
  end
  // transmit event element: sequence word, then time-stamp word
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ev_pend_q <= 1'b0;
      ev_word_q <= 1'b0;
      ev_slot_q <= 4'h0;
      ev_seq_q <= 8'h00;
    end
    else
    begin
      if (gnt == CBT_GNT_EVT)
      begin
        ev_word_q <= !ev_word_q;
        if (ev_word_q)
        begin
          ev_pend_q <= 1'b0;
          ev_seq_q <= ev_seq_q + 8'h01;
          ev_slot_q <= (ev_slot_q == 4'(TXE_DEPTH - 1)) ? 4'h0 : ev_slot_q + 4'h1;
        end
      end
      if (tx_done_i)
        ev_pend_q <= 1'b1;
    end
  end

  // ========================================================
  // outputs
  assign miso_o = miso_q;
  assign miso_oe_o = miso_oe_q;
  assign rx_bit_o = rxb_q;
  assign rx_bit_strobe_o = strobe_q;
  assign bit_start_o = bstart_q;
  assign segment_o = seg_q;
  assign init_mode_o = init_q;
  assign ecc_corrected_o = corr_o_q;
  assign uncorrectable_memory_error_o = unc_q;

  // ========================================================
  // checks
  logic [9:0] gap_q;
  logic [17:0] bc_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gap_q <= 10'h000;
      bc_q <= 18'h00000;
    end
    else
    begin
      gap_q <= (!run || tq_en) ? 10'h000 : gap_q + 10'h001;
      bc_q <= (!run || (tq_en && bitlast)) ? 18'h00000 : bc_q + 18'h00001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_ph1_end;
    tq_en && !fast_q && n_idx == 9'(tm[`CBT_F_TS1]) + 9'h002;
  endsequence
  sequence s_bad_read;
    rd_go_q && addr_q[`CBT_MEM_SEL] && !wval_q[mem_idx];
  endsequence
  AST_TQ_DIV:
  assert property (tq_en |-> gap_q == 10'(tm[`CBT_F_PRE]))
    else $error("quantum tick spacing differs from prescaler plus one");
  AST_BIT_LEN:
  assert property (tq_en && bitlast |-> int'(bc_q) + 1 ==
    (int'(tm[`CBT_F_PRE]) + 1) * (int'(tm[`CBT_F_TS1]) + int'(tm[`CBT_F_TS2]) + 3))
    else $error("bit length in clocks is wrong");
  AST_SYNC_ONE:
  assert property (tq_en && seg_q == CBT_SEG_SYNC |=> seg_q == CBT_SEG_PH1)
    else $error("sync segment did not last one quantum");
  AST_SAMPLE_POINT:
  assert property (s_ph1_end |=> strobe_q && seg_q == CBT_SEG_PH2 && rxb_q == $past(can_rx_i))
    else $error("bus not sampled at phase boundary");
  AST_TDC_SHIFT:
  assert property (tq_en && fast_q && tdc_q[`CBT_F_TDCO] != 7'h00 &&
    n_idx == 9'(tm[`CBT_F_TS1]) + 9'h002 |=> !strobe_q)
    else $error("compensated sample taken too early");
  AST_FRESH_WORD:
  assert property (s_bad_read |-> ##2 unc_q)
    else $error("read of unwritten word not flagged");
  AST_INIT_ON_ERR:
  assert property (unc_evt |=> init_q)
    else $error("memory fault did not force init");
  AST_LOCKED_LAYOUT:
  assert property (wr_reg && !prot_ok |=> $stable(nbt_q) && $stable(base_q[0]))
    else $error("protected register changed outside configuration");
  AST_WRAP:
  assert property (wr_go_q && addr_q[`CBT_MEM_SEL] |=>
    wval_q[last_idx_q] && mem_q[last_idx_q][31:0] == $past(wd_q))
    else $error("host write did not land at wrapped word");
  AST_RX_ANCHOR:
  assert property (frame_start_i |=> rx_widx_q == 9'h000)
    else $error("receive buffer index not rewound");
endmodule
`default_nettype wire

//--- verif/cbt_host.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_host (
  // clock
  input wire logic clk_i,
  // serial lines
  output logic cs_b_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // ========================================================
  // idle levels: deselected, clock low
  initial
  begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // one frame: direction, 16 address bits, 32 data bits, msb first
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    logic [48:0] f;
    f = {rd, a, d};
    q = 32'h0;
    @(posedge clk_i) cs_b_o <= 1'b0;
    for (int i = 48; i >= 0; i--)
    begin
      @(posedge clk_i) mosi_o <= f[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      // read data has settled since the previous fall
      if (i < 32)
        q = {q[30:0], miso_i};
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i) cs_b_o <= 1'b1;
    // data line no longer holds the last bit once deselected
    mosi_o <= ~mosi_o;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- verif/can_bit_timing_and_message_ram_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbt_cfg.svh"
module can_bit_timing_and_message_ram_test;
  import cbt_pkg::*;
  // ========================================================
  // clock, reset and wires
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic can_rx_i = 1'b1;
  logic data_ph = 1'b0;
  logic f_start = 1'b0;
  logic tx_dn = 1'b0;
  int n_corr = 0;
  logic cs_b, sclk, mosi, miso, miso_oe, rx_bit, rx_stb, bit_st, init_m, corr, unc;
  cbt_seg_t seg;
  int errors = 0;
  int n_tests = 0;
  int n;
  logic [31:0] q;
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  // device and host model
  cbt_core dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sclk_i(sclk),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .can_rx_i(can_rx_i),
    .data_phase_i(data_ph), .frame_start_i(f_start), .tx_done_i(tx_dn), .rx_bit_o(rx_bit),
    .rx_bit_strobe_o(rx_stb), .bit_start_o(bit_st), .segment_o(seg),
    .init_mode_o(init_m), .ecc_corrected_o(corr), .uncorrectable_memory_error_o(unc));
  cbt_host host_u (.clk_i(clk_i), .cs_b_o(cs_b), .sclk_o(sclk), .mosi_o(mosi),
    .miso_i(miso));
  // counts corrected-error pulses; no scenario injects a bit error
  always @(negedge clk_i)
  begin
    if (rst_b_i && corr !== 1'b0)
      n_corr++;
  end
  // ========================================================
  // access and compare tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    host_u.xfer(1'b0, a, d, x);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    host_u.xfer(1'b1, a, 32'h0, d);
  endtask
  // clocks up to and including the next bit start pulse, or sample strobe when stb is set
  task automatic wait_bs(input logic stb, output int c);
    c = 0;
    do
    begin
      @(negedge clk_i);
      c++;
    end
    while ((stb ? rx_stb : bit_st) !== 1'b1 && c < 200);
  endtask
  // one-cycle transmission done and frame start pulses from the protocol side
  task automatic pulse_tx;
    @(posedge clk_i);
    tx_dn <= 1'b1;
    f_start <= 1'b1;
    @(posedge clk_i);
    tx_dn <= 1'b0;
    f_start <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ========================================================
  // test sequence
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(`CBT_OFS_NBT, q);
    chk("nbt", 32'h02030601, q);
    chk("oe idle", 32'h00000000, {31'h0, miso_oe});
    rd(`CBT_OFS_DBT, q);
    chk("dbt", 32'h02030601, q);
    rd(`CBT_OFS_TDC, q);
    chk("tdc", 32'h00000000, q);
    wr(`CBT_OFS_NBT, 32'h02010201);
    rd(`CBT_OFS_NBT, q);
    chk("nbt locked", 32'h02030601, q);
    $display("test reset_and_lock done");
    wr(`CBT_OFS_CTRL, 32'h00000003);
    wr(`CBT_OFS_NBT, 32'h02010201);
    wr(`CBT_OFS_DBT, 32'h06000303);
    wr(`CBT_OFS_TDC, 32'h00000002);
    wr(`CBT_OFS_TXEV, 32'h00000259);
    rd(`CBT_OFS_TXEV, q);
    chk("evt base", 32'h00000258, q);
    can_rx_i <= 1'b0;
    wr(`CBT_OFS_CTRL, 32'h00000000);
    wait_bs(1'b0, n);
    wait_bs(1'b0, n);
    chk("bit clks", 32'h0000000C, n);
    chk("rx bit", 32'h00000000, {31'h0, rx_bit});
    chk("seg at start", 32'h00000000, {30'h0, seg});
    wait_bs(1'b1, n);
    chk("sample clks", 32'h00000008, n);
    @(posedge clk_i) data_ph <= 1'b1;
    wait_bs(1'b0, n);
    wait_bs(1'b0, n);
    chk("fast bit clks", 32'h00000009, n);
    wait_bs(1'b1, n);
    chk("fast sample clks", 32'h00000007, n);
    @(posedge clk_i) data_ph <= 1'b0;
    $display("test bit_timing done");
    rd(16'h8010, q);
    chk("unc", 32'h00000001, {31'h0, unc});
    chk("init", 32'h00000001, {31'h0, init_m});
    wr(16'h8004, 32'hA5A51234);
    rd(16'h8804, q);
    chk("wrap", 32'hA5A51234, q);
    rd(`CBT_OFS_STAT, q);
    chk("status", 32'h00000011, q);
    wr(`CBT_OFS_STAT, 32'h00000001);
    chk("unc cleared", 32'h00000000, {31'h0, unc});
    for (int k = 0; k < 4; k++)
      wr(16'h8000 + 16'(4 * k), {16'h1111, 16'(k)});
    rd(16'h800C, q);
    chk("tx payload", 32'h11110003, q);
    chk("unc clean", 32'h00000000, {31'h0, unc});
    $display("test memory done");
    pulse_tx();
    rd(16'h8258, q);
    chk("event seq 0", 32'h00000000, q);
    pulse_tx();
    rd(16'h8260, q);
    chk("event seq 1", 32'h00000001, q);
    chk("unc events", 32'h00000000, {31'h0, unc});
    chk("corr pulses", 32'h00000000, n_corr);
    $display("test events done");
    summarize();
  end
  // watchdog
  initial
  begin
    #1000000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
